// ---- bench/backlight_bias_i2c_register_port_tb.sv ----
`timescale 1ns/1ps
module backlight_bias_i2c_register_port_tb;
  import blc_pkg::*;
  localparam logic [3:0] REV_VAL   = 4'h9; // Arbitrary value
  localparam logic [1:0] MAKER_VAL = 2'h2; // Arbitrary value
  localparam logic [7:0] DEFS [0:19] = '{8'h00, 8'h00, RST_BL_CFG_ONE, RST_BL_CFG_TWO,
    RST_BRT_LOW, RST_BRT_HIGH, RST_AF_LOW, RST_AF_HIGH, RST_OUT_ENABLE, RST_BIAS_ONE,
    RST_BIAS_TWO, RST_BIAS_THREE, RST_BOOST_LEVEL, RST_POS_LEVEL, RST_NEG_LEVEL, 8'h00,
    RST_BL_OPT_ONE, RST_BL_OPT_TWO, 8'h00, 8'h00};
  logic        clk;
  logic        sys_rst;
  logic        clk_en;
  logic        hw_en;
  logic        scl;
  logic        sda;
  logic        sda_out;
  logic        sda_oe;
  status_in_t  status_in;
  bl_cfg_one_t bl_cfg_one;
  logic [7:0]  output_enable;
  logic [10:0] brightness;
  logic [7:0]  mdl [0:19];
  logic [7:0]  wbuf [0:31];
  logic [7:0]  fault_acc;
  logic [31:0] seed;
  logic        ack;
  int          fail_count;
  int          total_checks;

  blc_i2c_port #(.SILICON_REVISION(REV_VAL), .MAKER_CODE(MAKER_VAL)) u_blc_i2c_port (
    .clk(clk), .sys_rst(sys_rst), .clk_en(clk_en), .hardware_enable_pin(hw_en),
    .scl_in(scl), .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe), .status_in(status_in),
    .bl_cfg_one(bl_cfg_one), .output_enable(output_enable), .brightness(brightness));
  i2c_host u_i2c_host (.clk(clk), .sda_oe(sda_oe), .sda_out(sda_out), .scl(scl), .sda(sda));

  always #2.5 clk = ~clk;

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [7:0] exp_of(input logic [7:0] a);
    if (a == OFS_REVISION) return {2'b00, REV_VAL, MAKER_VAL};
    if (a == OFS_FAULT_FLAGS) return fault_acc;
    if (a == OFS_DUTY_LOW) return status_in.duty_low;
    if (a == OFS_DUTY_HIGH) return status_in.duty_high;
    if (a == 8'h00 || a > OFS_DUTY_HIGH) return 8'h00;
    return mdl[a[4:0]];
  endfunction
  task automatic mdl_write(input logic [7:0] a, input logic [7:0] d);
    if (a == OFS_OUT_ENABLE && d[SOFT_RESET_BIT_POS]) begin
      mdl = DEFS;
    end else if (a > OFS_REVISION && a < OFS_DUTY_LOW && a != OFS_FAULT_FLAGS) begin
      mdl[a[4:0]] = d;
    end
  endtask
  task automatic check(input string name, input logic [10:0] seen, input logic [10:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic write_burst(input logic [7:0] a, input int n);
    u_i2c_host.start_c();
    u_i2c_host.tx_byte({TARGET_ADDR, 1'b0}, ack);
    check("addr ack", 11'(ack), 11'h001);
    u_i2c_host.tx_byte(a, ack);
    check("ptr ack", 11'(ack), 11'h001);
    for (int i = 0; i < n; i++) begin
      u_i2c_host.tx_byte(wbuf[i], ack);
      check("data ack", 11'(ack), 11'h001);
      mdl_write(a + 8'(i), wbuf[i]);
    end
    u_i2c_host.stop_c();
  endtask
  task automatic read_burst(input logic [7:0] a, input int n);
    logic [7:0] d;
    logic [7:0] e;
    u_i2c_host.start_c();
    u_i2c_host.tx_byte({TARGET_ADDR, 1'b0}, ack);
    u_i2c_host.tx_byte(a, ack);
    u_i2c_host.start_c();
    u_i2c_host.tx_byte({TARGET_ADDR, 1'b1}, ack);
    check("read addr ack", 11'(ack), 11'h001);
    for (int i = 0; i < n; i++) begin
      e = exp_of(a + 8'(i));
      u_i2c_host.rx_byte(i == n - 1, d);
      check("read data", 11'(d), 11'(e));
      if (a + 8'(i) == OFS_FAULT_FLAGS) fault_acc = status_in.fault;
    end
    u_i2c_host.stop_c();
    check("sda released", 11'(sda_oe), 11'h000);
  endtask
  task automatic fill(input logic [7:0] a, input int n);
    for (int i = 0; i < n; i++) begin
      seed = lfsr(seed);
      wbuf[i] = seed[7:0];
      // Enables stay off so restricted fields may change
      if (a + 8'(i) == OFS_OUT_ENABLE) wbuf[i] = wbuf[i] & 8'h6C;
      if (a + 8'(i) == OFS_BRT_LOW) wbuf[i] = wbuf[i] & 8'h07;
    end
    status_in.duty_low = seed[15:8];
    status_in.duty_high = seed[23:16];
  endtask
  task automatic ports(input string name);
    check(name, 11'(bl_cfg_one), 11'(mdl[2]));
    check(name, 11'(output_enable), 11'(mdl[8]));
    check(name, brightness, {mdl[5], mdl[4][2:0]});
  endtask
  task automatic results();
    $display("Checks %0d, mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  initial begin
    #450000;
    fail_count++;
    results();
  end

  initial begin
    clk = 1'b0;
    sys_rst = 1'b1;
    clk_en = 1'b1;
    hw_en = 1'b1;
    status_in = '0;
    seed = 32'h0FED;
    fault_acc = 8'h00;
    fail_count = 0;
    total_checks = 0;
    mdl = DEFS;
    repeat (12) @(posedge clk);
    #1 sys_rst = 1'b0;
    repeat (8) @(posedge clk);
    #1;
    ports("reset ports");
    fill(8'h00, 1);
    read_burst(8'h00, 22);
    // Neighbours of the own address must stay silent
    for (int i = 0; i < 2; i++) begin
      u_i2c_host.start_c();
      u_i2c_host.tx_byte({TARGET_ADDR + 7'(2 * i) - 7'h1, 1'b0}, ack);
      check("foreign addr", 11'(ack), 11'h000);
      u_i2c_host.stop_c();
    end
    // Burst runs over read-only and unmapped places
    fill(8'h02, 20);
    write_burst(8'h02, 20);
    ports("burst ports");
    // Frozen clock enable: a short shutdown pulse must go unseen
    clk_en = 1'b0;
    hw_en = 1'b0;
    repeat (4) @(posedge clk);
    #1 hw_en = 1'b1;
    clk_en = 1'b1;
    repeat (4) @(posedge clk);
    #1;
    ports("frozen ports");
    read_burst(8'h00, 22);
    // Sticky flags: short pulse, then cleared by the read
    status_in.fault = 8'h45;
    repeat (8) @(posedge clk);
    #1 status_in.fault = 8'h00;
    fault_acc = 8'h45;
    read_burst(OFS_FAULT_FLAGS, 1);
    read_burst(OFS_FAULT_FLAGS, 1);
    wbuf[0] = 8'h80;
    write_burst(OFS_OUT_ENABLE, 1);
    ports("soft reset");
    read_burst(8'h02, 8);
    fill(OFS_BL_CFG_ONE, 4);
    write_burst(OFS_BL_CFG_ONE, 4);
    hw_en = 1'b0;
    repeat (6) @(posedge clk);
    #1 mdl = DEFS;
    fault_acc = 8'h00;
    ports("hw disable");
    u_i2c_host.start_c();
    u_i2c_host.tx_byte({TARGET_ADDR, 1'b0}, ack);
    check("disabled ack", 11'(ack), 11'h000);
    u_i2c_host.stop_c();
    hw_en = 1'b1;
    repeat (6) @(posedge clk);
    read_burst(8'h02, 8);
    for (int k = 0; k < 10; k++) begin
      seed = lfsr(seed);
      fill({3'b000, seed[4:0]}, 1);
      write_burst({3'b000, seed[4:0]}, 1);
      read_burst({3'b000, seed[4:0]}, 2);
    end
    results();
  end
endmodule

// ---- bench/i2c_host.sv ----
`timescale 1ns/1ps
module i2c_host (
  input  wire logic clk,
  input  wire logic sda_oe,
  input  wire logic sda_out,
  output logic      scl,
  output logic      sda
);
  logic host_low;
  // Pull-up: a line nobody pulls reads high
  assign sda = !(host_low || (sda_oe && !sda_out));
  initial begin
    scl      = 1'b1;
    host_low = 1'b0;
  end
  // Moves stay clear of clock edges
  task automatic wait_clk(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // Data changes only mid-low, so the synced edges never race
  task automatic bit_io(input logic b, output logic r);
    wait_clk(8);
    host_low = !b;
    wait_clk(8);
    scl = 1'b1;
    wait_clk(14);
    r = sda;
    wait_clk(2);
    scl = 1'b0;
  endtask
  // Also serves as repeated start when the clock is low
  task automatic start_c();
    if (!scl) begin
      wait_clk(8);
      host_low = 1'b0;
      wait_clk(8);
      scl = 1'b1;
    end
    wait_clk(16);
    host_low = 1'b1;
    wait_clk(16);
    scl = 1'b0;
  endtask
  task automatic stop_c();
    wait_clk(8);
    host_low = 1'b1;
    wait_clk(8);
    scl = 1'b1;
    wait_clk(16);
    host_low = 1'b0;
    wait_clk(32);
  endtask
  task automatic tx_byte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], r);
    end
    bit_io(1'b1, r);
    ack = !r;
  endtask
  task automatic rx_byte(input logic last, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, r);
      d[i] = r;
    end
    bit_io(last, r);
  endtask
endmodule

// ---- verilog/blc_i2c_port.sv ----
`timescale 1ns/1ps
// Contract
// R1 - Host sends 7-bit address, write bit; device acks only its own address.
// R2 - After address ack, host sends 8-bit pointer; device acks and loads it.
// R3 - Each following written data byte stored at pointer and acknowledged.
// R4 - Pointer increments by one after each acknowledged write byte.
// R5 - Host ends write with stop after final acknowledged byte.
// R6 - Host reads via pointer write phase then repeated start, no stop.
// R7 - After repeated start, address with read bit acked; device drives pointed byte.
// R8 - Host ack on read byte advances pointer and sends next register.
// R9 - Host nacks last read byte then stops; device releases data line.
// R10 - Host changes restricted settings only while enable bits 1:0 and 4 are zero. The code does not check the enable bits on writes.
// R11 - Restricted: cfg one 3:0, cfg two 6:0, option one 0,1,4:3, thresholds.
// R12 - Reset puts every register at its listed default value.
// R13 - Revision, flags and duty readback registers are read-only.
// R14 - Revision register: silicon revision high bits, 2-bit maker code low bits.
// R15 - Config one: overvoltage level, action, mapping, polarity, ramp, enable; 0x28.
// R16 - Device answers fixed 7-bit target address 0x11.
// R17 - Reading flags register clears the reported fault flags.
// R18 - Writing enable bit 7 resets all registers, then bit self-clears. The code does not clear the fault flags on it.
// R19 - Hardware enable low disables port and holds registers at defaults.
// R20 - Unmapped addresses acked; writes ignored, reads return zero.
module blc_i2c_port
  import blc_pkg::*;
#(
  parameter logic [3:0] SILICON_REVISION = 4'h0, // Arbitrary value
  parameter logic [1:0] MAKER_CODE       = 2'h2  // Arbitrary value
) (
  input  wire logic        clk,
  input  wire logic        sys_rst,
  input  wire logic        clk_en,
  input  wire logic        hardware_enable_pin,
  input  wire logic        scl_in,
  input  wire logic        sda_in,
  output logic             sda_out,
  output logic             sda_oe,
  input  wire status_in_t  status_in,
  output bl_cfg_one_t      bl_cfg_one,
  output logic [7:0]       output_enable,
  output logic [10:0]      brightness
);

  localparam int NREG = REG_COUNT;

  typedef struct packed {
    logic [1:0]      scl_s;
    logic [1:0]      sda_s;
    logic [1:0]      hw_s;
    logic            scl_d;
    logic            sda_d;
    link_state_t     st;
    logic [2:0]      bit_cnt;
    logic [7:0]      shift;
    logic            is_ptr;
    logic            addr_ok;
    logic            armed;
    logic            rd;
    logic [7:0]      ptr;
    logic [NREG-1:0][7:0] regs;
    logic [7:0]      fault_seen;
    logic            sda_out;
    logic            sda_oe;
  } state_t;

  state_t s_r;
  state_t s_nxt;

  function automatic logic [NREG-1:0][7:0] defaults();
    logic [NREG-1:0][7:0] d;
    d = '0;
    d[OFS_BL_CFG_ONE]  = RST_BL_CFG_ONE; // R15
    d[OFS_BL_CFG_TWO]  = RST_BL_CFG_TWO;
    d[OFS_BRT_LOW]     = RST_BRT_LOW;
    d[OFS_BRT_HIGH]    = RST_BRT_HIGH;
    d[OFS_AF_LOW]      = RST_AF_LOW;
    d[OFS_AF_HIGH]     = RST_AF_HIGH;
    d[OFS_OUT_ENABLE]  = RST_OUT_ENABLE;
    d[OFS_BIAS_ONE]    = RST_BIAS_ONE;
    d[OFS_BIAS_TWO]    = RST_BIAS_TWO;
    d[OFS_BIAS_THREE]  = RST_BIAS_THREE;
    d[OFS_BOOST_LEVEL] = RST_BOOST_LEVEL;
    d[OFS_POS_LEVEL]   = RST_POS_LEVEL;
    d[OFS_NEG_LEVEL]   = RST_NEG_LEVEL;
    d[OFS_BL_OPT_ONE]  = RST_BL_OPT_ONE;
    d[OFS_BL_OPT_TWO]  = RST_BL_OPT_TWO;
    return d;
  endfunction

  function automatic logic writable(input logic [7:0] a);
    return a >= OFS_BL_CFG_ONE && a < OFS_DUTY_LOW && a != OFS_FAULT_FLAGS; // R13
  endfunction

  logic [7:0] rd_data;
  logic       scl_rise;
  logic       scl_fall;
  logic       start_c;
  logic       stop_c;

  assign scl_rise = s_r.scl_s[1] & ~s_r.scl_d;
  assign scl_fall = ~s_r.scl_s[1] & s_r.scl_d;
  assign start_c  = s_r.scl_s[1] & s_r.scl_d & s_r.sda_d & ~s_r.sda_s[1];
  assign stop_c   = s_r.scl_s[1] & s_r.scl_d & ~s_r.sda_d & s_r.sda_s[1];

  always_comb begin
    rd_data = 8'h00; // R20
    if (s_r.ptr == OFS_REVISION) begin
      rd_data = {2'b00, SILICON_REVISION, MAKER_CODE}; // R14
    end else if (s_r.ptr == OFS_FAULT_FLAGS) begin
      rd_data = s_r.fault_seen;
    end else if (s_r.ptr == OFS_DUTY_LOW) begin
      rd_data = status_in.duty_low;
    end else if (s_r.ptr == OFS_DUTY_HIGH) begin
      rd_data = status_in.duty_high;
    end else if (s_r.ptr < 8'(NREG)) begin
      rd_data = s_r.regs[s_r.ptr[4:0]];
    end
  end

  always_comb begin
    s_nxt = s_r;
    s_nxt.scl_s = {s_r.scl_s[0], scl_in};
    s_nxt.sda_s = {s_r.sda_s[0], sda_in};
    s_nxt.hw_s  = {s_r.hw_s[0], hardware_enable_pin};
    s_nxt.scl_d = s_r.scl_s[1];
    s_nxt.sda_d = s_r.sda_s[1];
    // Faults latch until read; a new fault in the read cycle survives
    s_nxt.fault_seen = s_r.fault_seen | status_in.fault;
    if (!s_r.hw_s[1]) begin
      // Held in shutdown: port off, registers at default
      s_nxt.st      = ST_IDLE; // R19
      s_nxt.regs    = defaults(); // R19
      s_nxt.fault_seen = 8'h00;
      s_nxt.sda_oe  = 1'b0;
      s_nxt.sda_out = 1'b0;
    end else if (start_c) begin
      s_nxt.st      = ST_ADDR;
      s_nxt.bit_cnt = 3'd0;
      // The start's own clock fall must not end a byte
      s_nxt.armed   = 1'b0;
      s_nxt.sda_oe  = 1'b0;
    end else if (stop_c) begin
      s_nxt.st      = ST_IDLE;
      s_nxt.sda_oe  = 1'b0; // R9
    end else begin
      unique case (s_r.st)
        ST_IDLE: begin
        end
        ST_ADDR, ST_RX: begin
          if (scl_rise) begin
            s_nxt.shift   = {s_r.shift[6:0], s_r.sda_s[1]};
            s_nxt.bit_cnt = s_r.bit_cnt + 3'd1;
            s_nxt.armed   = 1'b1;
          end
          if (scl_fall && s_r.bit_cnt == 3'd0 && s_r.armed) begin
            if (s_r.st == ST_ADDR) begin
              s_nxt.addr_ok = s_r.shift[7:1] == TARGET_ADDR; // R1 R16
              s_nxt.rd      = s_r.shift[0];
              s_nxt.is_ptr  = ~s_r.shift[0];
              s_nxt.st      = ST_ADDR_ACK;
              s_nxt.sda_oe  = s_r.shift[7:1] == TARGET_ADDR; // R1 R7
            end else begin
              s_nxt.st     = ST_RX_ACK;
              s_nxt.sda_oe = 1'b1; // R3 R20
              if (s_r.is_ptr) begin
                s_nxt.ptr    = s_r.shift; // R2
                s_nxt.is_ptr = 1'b0;
              end else begin
                if (writable(s_r.ptr)) begin
                  s_nxt.regs[s_r.ptr[4:0]] = s_r.shift; // R3
                end
                if (s_r.ptr == OFS_OUT_ENABLE && s_r.shift[SOFT_RESET_BIT_POS]) begin
                  // Whole map returns to default, bit 7 reads back zero
                  s_nxt.regs = defaults(); // R18
                end
                s_nxt.ptr = s_r.ptr + 8'd1; // R4
              end
            end
            s_nxt.sda_out = 1'b0;
            s_nxt.armed   = 1'b0;
          end
        end
        ST_ADDR_ACK: begin
          if (scl_fall) begin
            s_nxt.bit_cnt = 3'd0;
            if (!s_r.addr_ok) begin
              s_nxt.st     = ST_IDLE;
              s_nxt.sda_oe = 1'b0;
            end else if (s_r.rd) begin
              s_nxt.st      = ST_TX;
              s_nxt.shift   = rd_data; // R7
              s_nxt.sda_out = 1'b0;
              s_nxt.sda_oe  = ~rd_data[7];
            end else begin
              s_nxt.st     = ST_RX;
              s_nxt.sda_oe = 1'b0;
            end
          end
        end
        ST_RX_ACK: begin
          if (scl_fall) begin
            s_nxt.st      = ST_RX;
            s_nxt.bit_cnt = 3'd0;
            s_nxt.sda_oe  = 1'b0;
          end
        end
        ST_TX: begin
          if (scl_fall) begin
            s_nxt.bit_cnt = s_r.bit_cnt + 3'd1;
            if (s_r.bit_cnt == 3'd7) begin
              s_nxt.st     = ST_TX_ACK;
              s_nxt.sda_oe = 1'b0;
              if (s_r.ptr == OFS_FAULT_FLAGS) begin
                s_nxt.fault_seen = status_in.fault; // R17
              end
            end else begin
              s_nxt.shift   = {s_r.shift[6:0], 1'b0};
              s_nxt.sda_oe  = ~s_r.shift[6];
            end
          end
        end
        ST_TX_ACK: begin
          if (scl_rise) begin
            s_nxt.rd = ~s_r.sda_s[1];
            if (!s_r.sda_s[1]) begin
              s_nxt.ptr = s_r.ptr + 8'd1; // R8
            end
          end
          if (scl_fall) begin
            if (s_r.rd) begin
              s_nxt.st    = ST_TX;
              s_nxt.bit_cnt = 3'd0;
              s_nxt.shift = rd_data; // R8
              s_nxt.sda_oe = ~rd_data[7];
            end else begin
              s_nxt.st = ST_IDLE; // R9
            end
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      s_r       <= '0;
      s_r.regs  <= defaults(); // R12
      s_r.scl_s <= 2'b11;
      s_r.sda_s <= 2'b11;
      s_r.scl_d <= 1'b1;
      s_r.sda_d <= 1'b1;
      s_r.st    <= ST_IDLE;
    end else if (clk_en) begin
      s_r <= s_nxt;
    end
  end

  // Open-drain: the line only ever gets pulled low
  assign sda_out       = s_r.sda_out;
  assign sda_oe        = s_r.sda_oe;
  assign bl_cfg_one    = bl_cfg_one_t'(s_r.regs[OFS_BL_CFG_ONE]); // R15
  assign output_enable = s_r.regs[OFS_OUT_ENABLE];
  assign brightness    = {s_r.regs[OFS_BRT_HIGH], s_r.regs[OFS_BRT_LOW][2:0]};

  sequence s_wr_byte_end;
    s_r.st == ST_RX && s_nxt.st == ST_RX_ACK && clk_en;
  endsequence

  a_addr_ack_match: assert property (@(posedge clk) disable iff (sys_rst)
    (s_r.st == ST_ADDR_ACK && !s_r.addr_ok) |-> !s_r.sda_oe) // R1
    else $error("ack on foreign address");
  a_ptr_advance: assert property (@(posedge clk) disable iff (sys_rst)
    (s_wr_byte_end and !s_r.is_ptr) |=> s_r.ptr == $past(s_r.ptr) + 8'd1) // R4
    else $error("pointer did not advance on write");
  a_ptr_load: assert property (@(posedge clk) disable iff (sys_rst)
    (s_wr_byte_end and s_r.is_ptr) |=> s_r.ptr == $past(s_r.shift)) // R2
    else $error("pointer not loaded");
  a_rx_ack_drive: assert property (@(posedge clk) disable iff (sys_rst)
    s_r.st == ST_RX_ACK |-> s_r.sda_oe) // R3
    else $error("data byte not acknowledged");
  a_ro_revision: assert property (@(posedge clk) disable iff (sys_rst)
    s_r.regs[OFS_FAULT_FLAGS] == 8'h00 && s_r.regs[OFS_DUTY_LOW] == 8'h00 // R13
    && s_r.regs[OFS_DUTY_HIGH] == 8'h00 && s_r.regs[OFS_REVISION] == 8'h00)
    else $error("read-only storage altered");
  a_hw_off_default: assert property (@(posedge clk) disable iff (sys_rst)
    (!s_r.hw_s[1] && clk_en) |=> s_r.regs == defaults() && s_r.st == ST_IDLE) // R19
    else $error("shutdown did not restore defaults");
  a_soft_rst_clr: assert property (@(posedge clk) disable iff (sys_rst)
    !s_r.regs[OFS_OUT_ENABLE][SOFT_RESET_BIT_POS]) // R18
    else $error("soft reset bit stuck");
  a_release_nack: assert property (@(posedge clk) disable iff (sys_rst)
    (s_r.st == ST_TX_ACK && scl_fall && !s_r.rd && clk_en)
    |=> s_r.st == ST_IDLE && !s_r.sda_oe) // R9
    else $error("line held after host nack");

endmodule

// ---- verilog/blc_pkg.sv ----
package blc_pkg;

  localparam logic [6:0] TARGET_ADDR      = 7'h11;
  localparam int         REG_COUNT        = 20;

  localparam logic [7:0] OFS_REVISION     = 8'h01;
  localparam logic [7:0] OFS_BL_CFG_ONE   = 8'h02;
  localparam logic [7:0] OFS_BL_CFG_TWO   = 8'h03;
  localparam logic [7:0] OFS_BRT_LOW      = 8'h04;
  localparam logic [7:0] OFS_BRT_HIGH     = 8'h05;
  localparam logic [7:0] OFS_AF_LOW       = 8'h06;
  localparam logic [7:0] OFS_AF_HIGH      = 8'h07;
  localparam logic [7:0] OFS_OUT_ENABLE   = 8'h08;
  localparam logic [7:0] OFS_BIAS_ONE     = 8'h09;
  localparam logic [7:0] OFS_BIAS_TWO     = 8'h0A;
  localparam logic [7:0] OFS_BIAS_THREE   = 8'h0B;
  localparam logic [7:0] OFS_BOOST_LEVEL  = 8'h0C;
  localparam logic [7:0] OFS_POS_LEVEL    = 8'h0D;
  localparam logic [7:0] OFS_NEG_LEVEL    = 8'h0E;
  localparam logic [7:0] OFS_FAULT_FLAGS  = 8'h0F;
  localparam logic [7:0] OFS_BL_OPT_ONE   = 8'h10;
  localparam logic [7:0] OFS_BL_OPT_TWO   = 8'h11;
  localparam logic [7:0] OFS_DUTY_LOW     = 8'h12;
  localparam logic [7:0] OFS_DUTY_HIGH    = 8'h13;

  localparam logic [7:0] RST_BL_CFG_ONE   = 8'h28;
  localparam logic [7:0] RST_BL_CFG_TWO   = 8'h8D;
  localparam logic [7:0] RST_BRT_LOW      = 8'h07;
  localparam logic [7:0] RST_BRT_HIGH     = 8'hFF;
  localparam logic [7:0] RST_AF_LOW       = 8'h00;
  localparam logic [7:0] RST_AF_HIGH      = 8'h00;
  localparam logic [7:0] RST_OUT_ENABLE   = 8'h00;
  localparam logic [7:0] RST_BIAS_ONE     = 8'h18;
  localparam logic [7:0] RST_BIAS_TWO     = 8'h11;
  localparam logic [7:0] RST_BIAS_THREE   = 8'h00;
  localparam logic [7:0] RST_BOOST_LEVEL  = 8'h28;
  localparam logic [7:0] RST_POS_LEVEL    = 8'h1E;
  localparam logic [7:0] RST_NEG_LEVEL    = 8'h1C;
  localparam logic [7:0] RST_BL_OPT_ONE   = 8'h06;
  localparam logic [7:0] RST_BL_OPT_TWO   = 8'h35;

  // Field positions
  localparam int SOFT_RESET_BIT_POS       = 7;
  localparam int OVL_LSB                  = 5;
  localparam int OVA_POS                  = 4;
  localparam int MAP_POS                  = 3;
  localparam int POL_POS                  = 2;
  localparam int RAMP_POS                 = 1;
  localparam int DUTY_EN_POS              = 0;
  localparam int MAKER_CODE_LSB           = 0;
  localparam int REVISION_LSB             = 2;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_ADDR,
    ST_ADDR_ACK,
    ST_RX,
    ST_RX_ACK,
    ST_TX,
    ST_TX_ACK
  } link_state_t;

  typedef struct packed {
    logic [2:0] overvoltage_level;
    logic       overvoltage_action;
    logic       current_mapping_select;
    logic       input_polarity;
    logic       duty_ramp;
    logic       duty_input_enable;
  } bl_cfg_one_t;

  typedef struct packed {
    logic [7:0] fault;
    logic [7:0] duty_low;
    logic [7:0] duty_high;
  } status_in_t;

endpackage
